// ===== logic/pbs_pkg.sv
// Purpose: shared constants and types of the push-button power sequencer
// Assumes: core clock of 100 MHz
// Notes: times are given in their own unit, cycle counts derived below
package pbs_pkg;
   // serial slave address, upper seven bits of the first byte
   localparam logic [6:0] DEV_ADDR = 7'h5A;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // register offsets
   localparam logic [7:0] REG_SYS = 8'h06;
   localparam logic [7:0] REG_LDO4 = 8'h40;
   localparam logic [7:0] REG_LDO5 = 8'h41;

   // field positions
   localparam int SYS_STAT_BIT = 0;
   localparam int SYS_UNMASK_BIT = 1;
   localparam int SYS_SPARE_BIT = 4;
   localparam int LDO_ON_BIT = 7;

   // reset values
   localparam logic SYS_UNMASK_RST = 1'b1;
   localparam logic SYS_SPARE_RST = 1'b0;
   localparam logic [7:0] LDO_RST = 8'hA0;

   // timing
   localparam int CLK_KHZ = 100_000;
   localparam int RST_TIME_MS = 260;
   localparam int RST_CYCLES = RST_TIME_MS * CLK_KHZ;
   localparam int DEB_TIME_MS = 5;
   localparam int DEB_CYCLES = DEB_TIME_MS * CLK_KHZ;

   typedef enum logic [2:0] {
      SEQ_OFF = 3'h0, SEQ_RAMP = 3'h1, SEQ_TIMER = 3'h3, SEQ_HOLD = 3'h2, SEQ_RUN = 3'h6
   } pbs_seq_t;

   typedef enum logic [3:0] {
      BUS_IDLE = 4'h0, BUS_ADDR = 4'h1, BUS_ACKA = 4'h3, BUS_REGA = 4'h2,
      BUS_ACKR = 4'h6, BUS_WDATA = 4'h7, BUS_ACKW = 4'h5, BUS_RDATA = 4'h4,
      BUS_RACK = 4'hC
   } pbs_bus_t;
endpackage : pbs_pkg

// ===== logic/pbs_sync.sv
// Purpose: two-stage synchroniser for inputs from outside the clock domain
// Assumes: inputs change slowly compared to the core clock
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module pbs_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } pbs_sync_st_t;

   pbs_sync_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.meta = din;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.stable;
endmodule : pbs_sync

// ===== logic/pbs_debounce.sv
// Purpose: debounce of active-low push-button levels
// Assumes: inputs already synchronised
// Notes: a level is taken only after it stood for CYCLES clocks
`timescale 1ns/1ps
module pbs_debounce #(
   parameter int W = 2,
   parameter int CYCLES = pbs_pkg::DEB_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   typedef struct packed {
      logic [W-1:0] level;
      logic [W-1:0][CW-1:0] cnt;
   } pbs_deb_st_t;

   pbs_deb_st_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      for (int i = 0; i < W; i++) begin
         if (din[i] == s_q.level[i]) begin
            s_d.cnt[i] = '0;
         end else if (s_q.cnt[i] == LAST) begin
            s_d.cnt[i] = '0;
            s_d.level[i] = din[i];
         end else begin
            s_d.cnt[i] = s_q.cnt[i] + 1'b1;
         end
      end
   end

   // released level after reset, so no press is seen at power-up
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s_q.level <= '1;
         s_q.cnt <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.level;
endmodule : pbs_debounce

// ===== logic/pbs_sequencer.sv
// Purpose: push-button power sequencer with serial register slave
// Assumes: analog comparators give buck one 94 percent and in-range flags
// Notes: open-drain pins drive low while their enable is high
`timescale 1ns/1ps
module pbs_sequencer #(
   parameter int RESET_CYCLES = pbs_pkg::RST_CYCLES,
   parameter int DEBOUNCE_CYCLES = pbs_pkg::DEB_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic pushbuttonInputN,
   input wire logic pushbuttonHardN,
   input wire logic enableInFirst,
   input wire logic enableInSecond,
   input wire logic enableInThird,
   input wire logic buckOneAt94,
   input wire logic buckOneInRange,
   input wire logic overTemp,
   output logic buckOneEn,
   output logic buckTwoEn,
   output logic buckThreeEn,
   output logic ldoFourEn,
   output logic ldoFiveEn,
   output logic systemResetOutN,
   output logic systemResetOutOe,
   output logic interruptOutN,
   output logic interruptOutOe
);
   localparam int TW = $clog2(RESET_CYCLES + 1);
   localparam logic [TW-1:0] TMR_LOAD = TW'(RESET_CYCLES);
   localparam logic [7:0] SYS_RO_MASK = 8'hEC;

   typedef struct packed {
      pbs_pkg::pbs_seq_t seq;
      logic [TW-1:0] tmr;
      logic [TW-1:0] hardTmr;
      pbs_pkg::pbs_bus_t bus;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic rw;
      logic nack;
      logic rdSeen;
      logic sdaLow;
      logic unmask;
      logic spare4;
      logic [7:0] ldo4;
      logic [7:0] ldo5;
      logic irq;
      logic rstOe;
      logic [4:0] en;
      logic sclD;
      logic sdaD;
      logic pressD;
   } pbs_top_st_t;

   pbs_top_st_t s_q, s_d;

   logic [8:0] syncOut;
   logic [1:0] pbDeb;
   logic sclS;
   logic sdaS;
   logic [2:0] enS;
   logic at94S;
   logic inRangeS;
   logic overTempS;
   logic pressed;
   logic hardPress;
   logic weakPress;
   logic pressEdge;
   logic anyEn;
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic irqSet;
   logic [7:0] rd;

   // every input pin except mclk and resetn passes two flops first
   pbs_sync #(.W(9)) u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .din({sclIn, sdaIn, pushbuttonInputN, pushbuttonHardN, enableInThird,
            enableInSecond, enableInFirst, buckOneAt94, buckOneInRange}),
      .dout(syncOut)
   );

   pbs_sync #(.W(1)) u_sync_temp (
      .mclk(mclk),
      .resetn(resetn),
      .din(overTemp),
      .dout(overTempS)
   );

   pbs_debounce #(.W(2), .CYCLES(DEBOUNCE_CYCLES)) u_deb (
      .mclk(mclk),
      .resetn(resetn),
      .din(syncOut[6:5]),
      .dout(pbDeb)
   );

   assign sclS = syncOut[8];
   assign sdaS = syncOut[7];
   assign enS = syncOut[4:2];
   assign at94S = syncOut[1];
   assign inRangeS = syncOut[0];
   assign pressed = ~pbDeb[1];
   assign hardPress = ~pbDeb[0];
   // weak press is low but not hard
   assign weakPress = pressed & ~hardPress;
   assign pressEdge = weakPress & ~s_q.pressD;
   assign anyEn = |enS;

   // start and stop while scl high
   assign startCond = sclS & s_q.sclD & s_q.sdaD & ~sdaS;
   assign stopCond = sclS & s_q.sclD & ~s_q.sdaD & sdaS;
   assign sclRise = sclS & ~s_q.sclD;
   assign sclFall = ~sclS & s_q.sclD;

   function automatic logic [7:0] regRead(
      input logic [7:0] a,
      input logic stat,
      input logic unm,
      input logic sp,
      input logic [7:0] l4,
      input logic [7:0] l5
   );
      logic [7:0] v;
      v = '0;
      if (a == pbs_pkg::REG_SYS) begin
         v[pbs_pkg::SYS_STAT_BIT] = stat;
         v[pbs_pkg::SYS_UNMASK_BIT] = unm;
         v[pbs_pkg::SYS_SPARE_BIT] = sp;
      end else if (a == pbs_pkg::REG_LDO4) begin
         v = l4;
      end else if (a == pbs_pkg::REG_LDO5) begin
         v = l5;
      end
      return v;
   endfunction : regRead

   assign rd = regRead(s_q.ptr, pressed, s_q.unmask, s_q.spare4, s_q.ldo4, s_q.ldo5);

   always_comb begin
      s_d = s_q;
      irqSet = 1'b0;
      s_d.sclD = sclS;
      s_d.sdaD = sdaS;
      s_d.pressD = weakPress;

      // serial slave; the master owns every clock edge
      if (startCond) begin
         s_d.bus = pbs_pkg::BUS_ADDR;
         s_d.cnt = '0;
         s_d.sdaLow = 1'b0;
      end else if (stopCond) begin
         s_d.bus = pbs_pkg::BUS_IDLE;
         s_d.sdaLow = 1'b0;
         s_d.rdSeen = 1'b0;
      end else begin
         // shift in msb first on rise
         if (sclRise) begin
            case (s_q.bus)
               pbs_pkg::BUS_ADDR, pbs_pkg::BUS_REGA, pbs_pkg::BUS_WDATA: begin
                  s_d.shift = {s_q.shift[6:0], sdaS};
                  s_d.cnt = s_q.cnt + 1'b1;
               end
               pbs_pkg::BUS_RDATA: begin
                  s_d.cnt = s_q.cnt + 1'b1;
               end
               pbs_pkg::BUS_RACK: begin
                  s_d.nack = sdaS;
               end
               default: begin
               end
            endcase
         end
         if (sclFall) begin
            case (s_q.bus)
               pbs_pkg::BUS_ADDR: begin
                  if (s_q.cnt == pbs_pkg::BYTE_BITS) begin
                     if (s_q.shift[7:1] == pbs_pkg::DEV_ADDR) begin
                        s_d.bus = pbs_pkg::BUS_ACKA;
                        s_d.sdaLow = 1'b1;
                        s_d.rw = s_q.shift[0];
                     end else begin
                        s_d.bus = pbs_pkg::BUS_IDLE;
                     end
                  end
               end
               pbs_pkg::BUS_ACKA: begin
                  s_d.cnt = '0;
                  if (s_q.rw) begin
                     s_d.bus = pbs_pkg::BUS_RDATA;
                     s_d.shift = rd;
                     s_d.sdaLow = ~rd[7];
                     s_d.rdSeen = 1'b1;
                  end else begin
                     s_d.bus = pbs_pkg::BUS_REGA;
                     s_d.sdaLow = 1'b0;
                  end
               end
               pbs_pkg::BUS_REGA: begin
                  if (s_q.cnt == pbs_pkg::BYTE_BITS) begin
                     s_d.ptr = s_q.shift;
                     s_d.bus = pbs_pkg::BUS_ACKR;
                     s_d.sdaLow = 1'b1;
                  end
               end
               pbs_pkg::BUS_ACKR, pbs_pkg::BUS_ACKW: begin
                  s_d.bus = pbs_pkg::BUS_WDATA;
                  s_d.cnt = '0;
                  s_d.sdaLow = 1'b0;
               end
               pbs_pkg::BUS_WDATA: begin
                  // one byte lands in the addressed register
                  if (s_q.cnt == pbs_pkg::BYTE_BITS) begin
                     s_d.bus = pbs_pkg::BUS_ACKW;
                     s_d.sdaLow = 1'b1;
                     if (s_q.ptr == pbs_pkg::REG_SYS) begin
                        s_d.unmask = s_q.shift[pbs_pkg::SYS_UNMASK_BIT];
                        s_d.spare4 = s_q.shift[pbs_pkg::SYS_SPARE_BIT];
                     end else if (s_q.ptr == pbs_pkg::REG_LDO4) begin
                        s_d.ldo4 = s_q.shift;
                     end else if (s_q.ptr == pbs_pkg::REG_LDO5) begin
                        s_d.ldo5 = s_q.shift;
                     end
                  end
               end
               pbs_pkg::BUS_RDATA: begin
                  if (s_q.cnt == pbs_pkg::BYTE_BITS) begin
                     s_d.bus = pbs_pkg::BUS_RACK;
                     s_d.sdaLow = 1'b0;
                  end else begin
                     s_d.shift = {s_q.shift[6:0], 1'b0};
                     s_d.sdaLow = ~s_q.shift[6];
                  end
               end
               pbs_pkg::BUS_RACK: begin
                  if (s_q.nack) begin
                     s_d.bus = pbs_pkg::BUS_IDLE;
                  end else begin
                     s_d.bus = pbs_pkg::BUS_RDATA;
                     s_d.cnt = '0;
                     s_d.shift = rd;
                     s_d.sdaLow = ~rd[7];
                  end
               end
               default: begin
               end
            endcase
         end
      end

      // hard press reloads the reset timeout
      if (hardPress) begin
         s_d.hardTmr = TMR_LOAD;
      end else if (s_q.hardTmr != '0) begin
         s_d.hardTmr = s_q.hardTmr - 1'b1;
      end

      case (s_q.seq)
         pbs_pkg::SEQ_OFF: begin
            if (pressEdge && !overTempS) begin
               s_d.seq = pbs_pkg::SEQ_RAMP;
            end
         end
         pbs_pkg::SEQ_RAMP: begin
            // wait for buck one at 94 percent
            if (!pressed && !anyEn) begin
               s_d.seq = pbs_pkg::SEQ_OFF;
            end else if (at94S) begin
               s_d.seq = pbs_pkg::SEQ_TIMER;
               s_d.tmr = TMR_LOAD;
            end
         end
         pbs_pkg::SEQ_TIMER: begin
            if (!pressed && !anyEn) begin
               s_d.seq = pbs_pkg::SEQ_OFF;
            end else if (s_q.tmr != '0) begin
               s_d.tmr = s_q.tmr - 1'b1;
            end else if (inRangeS) begin
               s_d.seq = pbs_pkg::SEQ_HOLD;
               irqSet = 1'b1;
            end
         end
         pbs_pkg::SEQ_HOLD: begin
            if (anyEn) begin
               s_d.seq = pbs_pkg::SEQ_RUN;
            end else if (!pressed) begin
               s_d.seq = pbs_pkg::SEQ_OFF;
            end
         end
         pbs_pkg::SEQ_RUN: begin
            // off when all enables drop, or on over-temperature below
            if (!anyEn) begin
               s_d.seq = pbs_pkg::SEQ_OFF;
            end
            if (pressEdge && s_q.unmask) begin
               irqSet = 1'b1;
            end
         end
         default: begin
            s_d.seq = pbs_pkg::SEQ_OFF;
         end
      endcase
      if (overTempS) begin
         s_d.seq = pbs_pkg::SEQ_OFF;
      end

      // set wins over the read clear
      if (irqSet) begin
         s_d.irq = 1'b1;
      end else if (stopCond && s_q.rdSeen) begin
         s_d.irq = 1'b0;
      end

      s_d.rstOe = (s_q.seq == pbs_pkg::SEQ_OFF) || (s_q.seq == pbs_pkg::SEQ_RAMP) ||
                  (s_q.seq == pbs_pkg::SEQ_TIMER) || hardPress || (s_q.hardTmr != '0);

      s_d.en = '0;
      case (s_q.seq)
         pbs_pkg::SEQ_RAMP: begin
            s_d.en[0] = 1'b1;
         end
         pbs_pkg::SEQ_TIMER, pbs_pkg::SEQ_HOLD: begin
            s_d.en = {2'b11, enS[2:1], 1'b1};
         end
         pbs_pkg::SEQ_RUN: begin
            s_d.en[2:0] = enS;
            s_d.en[3] = s_q.ldo4[pbs_pkg::LDO_ON_BIT];
            s_d.en[4] = s_q.ldo5[pbs_pkg::LDO_ON_BIT];
         end
         default: begin
         end
      endcase
      if (overTempS) begin
         s_d.en = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.unmask <= pbs_pkg::SYS_UNMASK_RST;
         s_q.spare4 <= pbs_pkg::SYS_SPARE_RST;
         s_q.ldo4 <= pbs_pkg::LDO_RST;
         s_q.ldo5 <= pbs_pkg::LDO_RST;
         s_q.rstOe <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // slave drives sda only, never scl
   assign sdaOut = 1'b0;
   assign sdaOe = s_q.sdaLow;
   assign {ldoFiveEn, ldoFourEn, buckThreeEn, buckTwoEn, buckOneEn} = s_q.en;
   assign systemResetOutN = 1'b0;
   assign systemResetOutOe = s_q.rstOe;
   assign interruptOutN = 1'b0;
   assign interruptOutOe = s_q.irq;

   chk_addr_match: assert property (
      @(posedge mclk) disable iff (!resetn)
      (s_q.bus == pbs_pkg::BUS_ACKA) |-> (s_q.shift[7:1] == pbs_pkg::DEV_ADDR))
      else $error("ack given to foreign address");

   chk_drive_idle: assert property (
      @(posedge mclk) disable iff (!resetn)
      (s_q.bus == pbs_pkg::BUS_IDLE) |-> !sdaOe)
      else $error("sda driven outside a transaction");

   chk_ack_low: assert property (
      @(posedge mclk) disable iff (!resetn)
      (sclFall && s_q.bus == pbs_pkg::BUS_WDATA && s_q.cnt == pbs_pkg::BYTE_BITS)
      |=> sdaOe && s_q.bus == pbs_pkg::BUS_ACKW)
      else $error("written byte not acknowledged");

   chk_mask_gate: assert property (
      @(posedge mclk) disable iff (!resetn)
      ($rose(s_q.irq) && $past(s_q.seq) == pbs_pkg::SEQ_RUN) |-> $past(s_q.unmask))
      else $error("masked button raised interrupt");

   chk_ro_zero: assert property (
      @(posedge mclk) disable iff (!resetn)
      (s_q.ptr == pbs_pkg::REG_SYS) |-> ((rd & SYS_RO_MASK) == 8'h00))
      else $error("read-only bits not zero");

   chk_hard_rst: assert property (
      @(posedge mclk) disable iff (!resetn)
      hardPress |=> systemResetOutOe ##1 systemResetOutOe)
      else $error("hard press did not hold reset");

   chk_run_hold: assert property (
      @(posedge mclk) disable iff (!resetn)
      (s_q.seq == pbs_pkg::SEQ_RUN && anyEn && !overTempS) |=> s_q.seq == pbs_pkg::SEQ_RUN)
      else $error("system left run with an enable");

   chk_tsd_off: assert property (
      @(posedge mclk) disable iff (!resetn)
      overTempS |=> (s_q.en == 5'h00) && (s_q.seq == pbs_pkg::SEQ_OFF))
      else $error("regulator on while hot");

   chk_rst_range: assert property (
      @(posedge mclk) disable iff (!resetn)
      ($past(s_q.seq) == pbs_pkg::SEQ_TIMER && s_q.seq == pbs_pkg::SEQ_HOLD)
      |-> $past(inRangeS) && $past(s_q.tmr) == '0)
      else $error("reset released out of range");

   chk_early_off: assert property (
      @(posedge mclk) disable iff (!resetn)
      (s_q.seq == pbs_pkg::SEQ_RAMP && !pressed && !anyEn) |=> s_q.seq == pbs_pkg::SEQ_OFF)
      else $error("no shutdown on early release");

   chk_irq_clear: assert property (
      @(posedge mclk) disable iff (!resetn)
      $fell(s_q.irq) |-> $past(stopCond) && $past(s_q.rdSeen))
      else $error("interrupt cleared without read");
endmodule : pbs_sequencer

// ===== tb/pbs_host_model.sv
// Purpose: bus master model of the system processor
// Assumes: data wire pulled up, bus clock period 160 ns
// Notes: clock rests high between frames
`timescale 1ns/1ps
module pbs_host_model (
   output logic scl,
   output logic sdaDrv,
   input wire logic sdaWire
);
   // only this model ever clocks the bus
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   // one bit or ack slot, sampled at the rise
   task automatic bit_io(input logic b, output logic r);
      sdaDrv = b;
      #40;
      scl = 1'b1;
      r = sdaWire;
      #80;
      scl = 1'b0;
      #40;
   endtask : bit_io
   // start: data falls while clock high
   task automatic start_cond();
      sdaDrv = 1'b1;
      #40;
      scl = 1'b1;
      #40;
      sdaDrv = 1'b0;
      #40;
      scl = 1'b0;
      #40;
   endtask : start_cond
   task automatic stop_cond();
      sdaDrv = 1'b0;
      #40;
      scl = 1'b1;
      #40;
      sdaDrv = 1'b1;
      #80;
   endtask : stop_cond
   // msb first, then the ack slot
   task automatic byte_io(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
      output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ackIn, ack);
   endtask : byte_io
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] off, d, output logic nak);
      logic [7:0] q;
      logic a0, a1, a2;
      start_cond();
      byte_io({dev, 1'b0}, 1'b1, q, a0);
      byte_io(off, 1'b1, q, a1);
      byte_io(d, 1'b1, q, a2);
      stop_cond();
      nak = a0 | a1 | a2;
   endtask : write_reg
   // single-byte read, master ends it with a nack
   task automatic read_reg(input logic [7:0] off, output logic [7:0] d, output logic nak);
      logic [7:0] q;
      logic a0, a1, a2, a3;
      start_cond();
      byte_io({pbs_pkg::DEV_ADDR, 1'b0}, 1'b1, q, a0);
      byte_io(off, 1'b1, q, a1);
      start_cond();
      byte_io({pbs_pkg::DEV_ADDR, 1'b1}, 1'b1, q, a2);
      byte_io(8'hFF, 1'b1, d, a3);
      stop_cond();
      nak = a0 | a1 | a2;
   endtask : read_reg
endmodule : pbs_host_model

// ===== tb/test_pbs_sequencer.sv
// Purpose: self-checking bench of the push-button power sequencer
// Assumes: short reset and debounce counts, open-drain pins pulled up
// Notes: driver queues expectations, a monitor compares them
`timescale 1ns/1ps
module test_pbs_sequencer;
   localparam int RC = 50;
   localparam int DC = 4;
   logic mclk, resetn, scl, sdaDrv, sdaW, sdaOe, pbN, hardN, en1, en2, en3;
   logic at94, inRange, overTemp, b1, b2, b3, l4, l5, rstOe, irqOe;
   logic sdaO, rstN, irqN;
   logic [8:0] seenVal;
   logic [8:0] expQ[$];
   logic [31:0] rng;
   int errors, n_checks, cyc;
   event resultEv;
   // open drain: only a driven low value reaches the wire
   assign sdaW = sdaDrv & ~(sdaOe & ~sdaO);
   pbs_host_model u_host (.scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaW));
   pbs_sequencer #(.RESET_CYCLES(RC), .DEBOUNCE_CYCLES(DC)) u_dut (
      .mclk(mclk), .resetn(resetn), .sclIn(scl), .sdaIn(sdaW), .sdaOut(sdaO), .sdaOe(sdaOe),
      .pushbuttonInputN(pbN), .pushbuttonHardN(hardN), .enableInFirst(en1),
      .enableInSecond(en2), .enableInThird(en3), .buckOneAt94(at94),
      .buckOneInRange(inRange), .overTemp(overTemp), .buckOneEn(b1), .buckTwoEn(b2),
      .buckThreeEn(b3), .ldoFourEn(l4), .ldoFiveEn(l5), .systemResetOutN(rstN),
      .systemResetOutOe(rstOe), .interruptOutN(irqN), .interruptOutOe(irqOe));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xorshift
   task automatic check(input logic [8:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      if (errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : cyc_wait
   // one cycle passes after each note so the monitor never misses one
   task automatic note(input logic [8:0] seen, exp);
      expQ.push_back(exp);
      seenVal = seen;
      -> resultEv;
      cyc_wait(1);
   endtask : note
   task automatic wr(input logic [7:0] off, d, input logic bad);
      logic nak;
      u_host.write_reg(bad ? 7'h5B : pbs_pkg::DEV_ADDR, off, d, nak);
      note({8'h00, nak}, {8'h00, bad});
   endtask : wr
   task automatic rd(input logic [7:0] off, exp);
      logic [7:0] d;
      logic nak;
      u_host.read_reg(off, d, nak);
      note({nak, d}, {1'b0, exp});
   endtask : rd
   initial begin
      forever begin
         @(resultEv);
         check(seenVal, expQ.pop_front());
      end
   end
   // a hang ends the run here
   always @(posedge mclk) begin
      cyc++;
      if (cyc >= 40000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      rng = 32'h1219BF9B;
      {resetn, pbN, hardN, en1, en2, en3, at94, inRange, overTemp} = 9'h0C0;
      cyc_wait(4);
      resetn = 1'b1;
      cyc_wait(3);
      note({2'h0, sdaO, rstN, irqN, rstOe, b1, l4, irqOe}, 9'h008);
      rd(pbs_pkg::REG_SYS, 8'h02);
      wr(pbs_pkg::REG_SYS, 8'hED, 1'b0);
      rd(pbs_pkg::REG_SYS, 8'h00);
      wr(pbs_pkg::REG_SYS, 8'h02, 1'b0);
      wr(pbs_pkg::REG_SYS, 8'h00, 1'b1);
      rd(pbs_pkg::REG_SYS, 8'h02);
      rd(8'h55, 8'h00);
      pbN = 1'b0;
      for (int k = 0; k < 40 && b1 !== 1'b1; k++) cyc_wait(1);
      note({5'h0, b1, l4, l5, rstOe}, 9'h009);
      at94 = 1'b1;
      for (int k = 0; k < 40 && l4 !== 1'b1; k++) cyc_wait(1);
      note({5'h0, b1, l4, l5, rstOe}, 9'h00F);
      cyc_wait(RC + 10);
      note({7'h0, rstOe, irqOe}, 9'h002);
      inRange = 1'b1;
      for (int k = 0; k < 40 && rstOe !== 1'b0; k++) cyc_wait(1);
      note({7'h0, rstOe, irqOe}, 9'h001);
      // processor takes its time before enabling
      cyc_wait(20);
      rng = xorshift(rng);
      {en3, en2, en1} = (rng[2:0] == 3'h0) ? 3'h5 : rng[2:0];
      cyc_wait(5);
      note({6'h0, b3, b2, b1}, {6'h0, en3, en2, en1});
      pbN = 1'b1;
      cyc_wait(DC + 10);
      note({5'h0, rstOe, b3, b2, b1}, {6'h0, en3, en2, en1});
      wr(pbs_pkg::REG_LDO4, 8'h20, 1'b0);
      note({8'h0, irqOe}, 9'h001);
      rng = xorshift(rng);
      wr(pbs_pkg::REG_LDO5, rng[7:0], 1'b0);
      rd(pbs_pkg::REG_LDO5, rng[7:0]);
      note({6'h0, irqOe, l4, l5}, {8'h0, rng[7]});
      pbN = 1'b0;
      cyc_wait(DC + 10);
      note({8'h0, irqOe}, 9'h001);
      rd(pbs_pkg::REG_SYS, 8'h03);
      pbN = 1'b1;
      wr(pbs_pkg::REG_SYS, 8'h00, 1'b0);
      pbN = 1'b0;
      cyc_wait(DC + 10);
      note({8'h0, irqOe}, 9'h000);
      {pbN, hardN} = 2'b00;
      cyc_wait(DC + 5);
      note({8'h0, rstOe}, 9'h001);
      {pbN, hardN} = 2'b11;
      cyc_wait(DC + RC - 10);
      note({8'h0, rstOe}, 9'h001);
      cyc_wait(20);
      note({8'h0, rstOe}, 9'h000);
      {en3, en2, en1} = 3'h0;
      cyc_wait(5);
      note({3'h0, rstOe, b1, b2, b3, l4, l5}, 9'h020);
      pbN = 1'b0;
      for (int k = 0; k < 40 && b1 !== 1'b1; k++) cyc_wait(1);
      overTemp = 1'b1;
      cyc_wait(5);
      note({6'h0, b1, l4, l5}, 9'h000);
      pbN = 1'b1;
      cyc_wait(DC + 5);
      pbN = 1'b0;
      cyc_wait(DC + 10);
      note({8'h0, b1}, 9'h000);
      {pbN, overTemp} = 2'b10;
      // buck one never reaches 94 percent, so the release comes in ramp
      at94 = 1'b0;
      cyc_wait(DC + 5);
      pbN = 1'b0;
      for (int k = 0; k < 40 && b1 !== 1'b1; k++) cyc_wait(1);
      note({8'h0, b1}, 9'h001);
      pbN = 1'b1;
      cyc_wait(DC + 10);
      note({6'h0, b1, l4, l5}, 9'h000);
      final_report();
   end
endmodule : test_pbs_sequencer
